// >>> asp_pkg.sv
// shared constants for the serial port with synchronous clock output
package asp_pkg;

  // register indices as printed or chosen, byte address is four times the index
  localparam logic [7:0] IDX_DATA  = 8'h11;
  localparam logic [7:0] IDX_CTL1  = 8'h12;
  localparam logic [7:0] IDX_CTL2  = 8'h13;
  localparam logic [7:0] IDX_FLAG  = 8'h14;
  localparam logic [7:0] IDX_BAUD  = 8'h15;
  localparam logic [7:0] ADDR_DATA = 8'(IDX_DATA * 4);
  localparam logic [7:0] ADDR_CTL1 = 8'(IDX_CTL1 * 4);
  localparam logic [7:0] ADDR_CTL2 = 8'(IDX_CTL2 * 4);
  localparam logic [7:0] ADDR_FLAG = 8'(IDX_FLAG * 4);
  localparam logic [7:0] ADDR_BAUD = 8'(IDX_BAUD * 4);

  // control_one fields
  localparam int C1_LAST_CLK = 0;
  localparam int C1_CLK_PHA  = 1;
  localparam int C1_CLK_POL  = 2;
  localparam int C1_WAKE     = 3;
  localparam int C1_NINE     = 4;
  localparam int C1_TX_BIT8  = 6;
  localparam int C1_RX_BIT8  = 7;
  localparam logic [7:0] C1_WR_MASK = 8'h5f;

  // control_two fields
  localparam int C2_BREAK    = 0;
  localparam int C2_SLEEP    = 1;
  localparam int C2_RX_ON    = 2;
  localparam int C2_TX_ON    = 3;
  localparam int C2_IDLE_IE  = 4;
  localparam int C2_RX_IE    = 5;
  localparam int C2_DONE_IE  = 6;
  localparam int C2_EMPTY_IE = 7;

  // flag_register fields
  localparam int F_FRAME = 1;
  localparam int F_NOISE = 2;
  localparam int F_OVER  = 3;
  localparam int F_IDLE  = 4;
  localparam int F_FULL  = 5;
  localparam int F_DONE  = 6;
  localparam int F_EMPTY = 7;

  // baud fields
  localparam int B_RX_LSB  = 0;
  localparam int B_PRE_LSB = 3;
  localparam int B_TX_LSB  = 5;

  localparam logic [7:0] RST_CTL1 = 8'h00;
  localparam logic [7:0] RST_CTL2 = 8'h00;
  localparam logic [7:0] RST_BAUD = 8'h00;
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_FLAG = 8'hc0;

  // receive timing in sample ticks
  localparam logic [3:0] RT_VOTE_A = 4'h7;
  localparam logic [3:0] RT_VOTE_B = 4'h8;
  localparam logic [3:0] RT_VOTE_C = 4'h9;
  localparam logic [3:0] RT_LAST   = 4'hf;
  localparam logic [3:0] RT_HALF   = 4'h8;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } asp_rx_state_t;

  typedef enum logic [1:0] {
    TK_DATA  = 2'b01,
    TK_OTHER = 2'b10
  } asp_tx_kind_t;

endpackage

// >>> asp_uart.sv
// serial port with oversampling receiver, synchronous clock output and ahb-lite registers
//
// The register addresses and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
module asp_uart
  import asp_pkg::*;
#(
  parameter logic [3:0] PRE_DIV_0 = 4'h1,
  parameter logic [3:0] PRE_DIV_1 = 4'h2,
  parameter logic [3:0] PRE_DIV_2 = 4'h4,
  parameter logic [3:0] PRE_DIV_3 = 4'h8
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        serial_in_pin,
  output logic             serial_out,
  output logic             serial_out_oe,
  output logic             sync_clk,
  output logic             sync_clk_oe,
  output logic             irq
);

  // prescale divide minus one, encoding set by parameters
  function automatic logic [3:0] pre_limit(input logic [1:0] sel);
    logic [3:0] d;
    d = PRE_DIV_0;
    case (sel)
      2'd1:    d = PRE_DIV_1;
      2'd2:    d = PRE_DIV_2;
      2'd3:    d = PRE_DIV_3;
      default: d = PRE_DIV_0;
    endcase
    pre_limit = (d == 4'h0) ? 4'h0 : d - 4'h1;
  endfunction

  // selector divides by two to the power sel
  function automatic logic rate_hit(input logic [6:0] cnt, input logic [2:0] sel);
    logic [6:0] mask;
    mask = 7'((8'h01 << sel) - 8'h01);
    rate_hit = (cnt & mask) == mask;
  endfunction

  function automatic logic majority(input logic a, input logic b, input logic c);
    majority = (a & b) | (a & c) | (b & c);
  endfunction

  logic [7:0] ctl1_q, ctl2_q, baud_q, flag_q;
  logic [7:0] tx_data_q, rx_data_q;
  logic       rx_bit8_q;

  // ---------------- bus slave ----------------
  logic       wr_pend_q;
  logic [7:0] wr_addr_q;
  logic       status_seen_q;
  logic [31:0] hrdata_q;
  wire        bus_take   = ce && hsel && hready && (htrans == HTRANS_NONSEQ);
  wire        bus_rd     = bus_take && !hwrite;
  wire        wr_fire    = ce && wr_pend_q;
  wire        wr_data    = wr_fire && (wr_addr_q == ADDR_DATA);
  wire        wr_ctl1    = wr_fire && (wr_addr_q == ADDR_CTL1);
  wire        wr_ctl2    = wr_fire && (wr_addr_q == ADDR_CTL2);
  wire        wr_baud    = wr_fire && (wr_addr_q == ADDR_BAUD);
  wire        rd_flag    = bus_rd && (haddr == ADDR_FLAG);
  wire        rd_data    = bus_rd && (haddr == ADDR_DATA);
  wire        rx_clear   = rd_data && status_seen_q;
  wire [7:0]  ctl1_view  = {rx_bit8_q, ctl1_q[6:0]};
  // same address is transmit on write, receive on read
  wire [7:0]  rd_mux =
      (haddr == ADDR_DATA) ? rx_data_q :
      (haddr == ADDR_CTL1) ? ctl1_view :
      (haddr == ADDR_CTL2) ? ctl2_q :
      (haddr == ADDR_FLAG) ? flag_q :
      (haddr == ADDR_BAUD) ? baud_q : 8'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q  <= 32'h0000_0000;
    end else if (ce) begin
      wr_pend_q <= bus_take && hwrite;
      if (bus_take) begin
        wr_addr_q <= haddr;
      end
      if (bus_rd) begin
        hrdata_q <= {24'h00_0000, rd_mux};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_seen_q <= 1'b0;
    end else if (ce && bus_take) begin
      status_seen_q <= rd_flag;
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ---------------- configuration ----------------
  wire tx_on     = ctl2_q[C2_TX_ON];
  wire rx_on     = ctl2_q[C2_RX_ON];
  wire nine_bits = ctl1_q[C1_NINE];
  logic rx_wake;

  // wake method and length in control_one, enables in control_two
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl1_q <= RST_CTL1;
      ctl2_q <= RST_CTL2;
      baud_q <= RST_BAUD;
    end else if (ce) begin
      if (wr_ctl1) begin
        ctl1_q <= hwdata[7:0] & C1_WR_MASK;
      end
      if (wr_ctl2) begin
        ctl2_q <= hwdata[7:0];
      end else if (rx_wake) begin
        ctl2_q[C2_SLEEP] <= 1'b0;
      end
      if (wr_baud) begin
        baud_q <= hwdata[7:0];
      end
    end
  end

  // ---------------- baud generation ----------------
  logic [3:0] pre_cnt_q;
  logic [6:0] rx_div_q, tx_div_q;
  // two prescale bits feed two 3-bit selectors
  wire [1:0] pre_sel   = baud_q[B_PRE_LSB +: 2];
  wire [2:0] rx_sel    = baud_q[B_RX_LSB +: 3];
  wire [2:0] tx_sel    = baud_q[B_TX_LSB +: 3];
  wire       pre_wrap  = pre_cnt_q >= pre_limit(pre_sel);
  wire       pre_tick  = ce && pre_wrap;
  // independent dividers behind the shared prescaler
  wire       rx_tick   = pre_tick && rate_hit(rx_div_q, rx_sel);
  wire       tx_rt     = pre_tick && rate_hit(tx_div_q, tx_sel);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt_q <= 4'h0;
      rx_div_q  <= 7'h00;
      tx_div_q  <= 7'h00;
    end else if (ce) begin
      pre_cnt_q <= pre_wrap ? 4'h0 : pre_cnt_q + 4'h1;
      if (pre_tick) begin
        rx_div_q <= rx_div_q + 7'h01;
        tx_div_q <= tx_div_q + 7'h01;
      end
    end
  end

  // ---------------- receiver ----------------
  logic          rx_s1_q, rx_s2_q;
  asp_rx_state_t rx_st_q;
  logic [3:0]    rt_q;
  logic [3:0]    rx_bit_q;
  logic [8:0]    rx_sh_q;
  logic [1:0]    vote_q;
  logic          rx_noise_q, rx_armed_q, rx_seen_q;
  logic [7:0]    idle_cnt_q;

  wire       line      = rx_s2_q;
  wire [3:0] data_len  = nine_bits ? 4'd9 : 4'd8;
  wire [7:0] idle_len  = nine_bits ? 8'd176 : 8'd160;
  wire       vote      = majority(vote_q[1], vote_q[0], line);
  wire       vote_bad  = !((vote_q[1] == vote_q[0]) && (vote_q[0] == line));
  wire       at_vote   = rx_tick && (rt_q == RT_VOTE_C);
  wire       stop_done = at_vote && (rx_st_q == RX_STOP);
  wire       sleeping  = ctl2_q[C2_SLEEP];
  wire [8:0] rx_frame  = nine_bits ? rx_sh_q : {1'b0, rx_sh_q[7:0]};
  wire       rx_addr   = nine_bits ? rx_sh_q[8] : rx_sh_q[7];
  wire       idle_hit  = rx_tick && line && (rx_st_q == RX_IDLE) && (idle_cnt_q == idle_len);
  // sleep suppresses every receive flag
  wire       rx_flags_ok = rx_on && !sleeping;
  wire       char_in   = stop_done && rx_flags_ok;
  wire       ovr_ev    = char_in && flag_q[F_FULL];
  wire       load_ev   = char_in && !flag_q[F_FULL];
  // idle only after a valid character, never while asleep
  wire       idle_ev   = idle_hit && rx_seen_q && rx_flags_ok;

  assign rx_wake = rx_on && sleeping && (ctl1_q[C1_WAKE] ? (stop_done && rx_addr) : idle_hit);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else if (ce) begin
      rx_s1_q <= serial_in_pin;
      rx_s2_q <= rx_s1_q;
    end
  end

  // 16 samples per bit, frame timed from the detected start edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st_q    <= RX_IDLE;
      rt_q       <= 4'h0;
      rx_bit_q   <= 4'h0;
      rx_sh_q    <= 9'h000;
      vote_q     <= 2'b11;
      rx_noise_q <= 1'b0;
      rx_armed_q <= 1'b0;
    end else if (rx_tick && rx_on) begin
      rt_q <= rt_q + 4'h1;
      if (rt_q == RT_VOTE_A || rt_q == RT_VOTE_B) begin
        vote_q <= {vote_q[0], line};
      end
      case (rx_st_q)
        RX_IDLE: begin
          if (line) begin
            rx_armed_q <= 1'b1;
          end else if (rx_armed_q) begin
            // after a break the line must go high before a new start
            rx_st_q    <= RX_START;
            rt_q       <= 4'h1;
            rx_noise_q <= 1'b0;
            rx_armed_q <= 1'b0;
          end
        end
        RX_START: begin
          if (rt_q == RT_VOTE_C) begin
            if (vote) begin
              rx_st_q    <= RX_IDLE;
              rx_armed_q <= 1'b1;
            end
            rx_noise_q <= vote_bad;
          end else if (rt_q == RT_LAST) begin
            rx_st_q  <= RX_DATA;
            rx_bit_q <= 4'h0;
          end
        end
        RX_DATA: begin
          if (rt_q == RT_VOTE_C) begin
            rx_sh_q[rx_bit_q] <= vote; // lsb first
            rx_noise_q        <= rx_noise_q | vote_bad;
          end else if (rt_q == RT_LAST) begin
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == data_len - 4'h1) begin
              rx_st_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rt_q == RT_VOTE_C) begin
            rx_st_q    <= RX_IDLE;
            rx_armed_q <= vote;
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end else if (ce && !rx_on) begin
      rx_st_q <= RX_IDLE;
    end
  end

  // holding register loads on the receive sample tick of the stop bit vote
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_data_q  <= RST_DATA;
      rx_bit8_q  <= 1'b0;
      rx_seen_q  <= 1'b0;
      idle_cnt_q <= 8'h00;
    end else if (ce) begin
      if (load_ev) begin
        rx_data_q <= rx_frame[7:0];
        rx_bit8_q <= rx_frame[8];
      end
      if (rx_tick) begin
        if (!line || rx_st_q != RX_IDLE) begin
          idle_cnt_q <= 8'h00;
        end else if (idle_cnt_q != idle_len) begin
          idle_cnt_q <= idle_cnt_q + 8'h01;
        end
      end
      if (char_in && vote) begin
        rx_seen_q <= 1'b1;
      end else if (idle_ev) begin
        rx_seen_q <= 1'b0;
      end
    end
  end

  // ---------------- transmitter ----------------
  logic         tx_busy_q, tx_on_prev_q, pre_pend_q;
  logic [3:0]   tx_sub_q, tx_left_q, tx_pos_q;
  logic [10:0]  tx_sh_q;
  asp_tx_kind_t tx_kind_q;
  logic         tx_out_q, tx_oe_q, sclk_q, sclk_oe_q;

  // fixed divide by sixteen ahead of the transmitter
  wire        tx_bit    = tx_rt && (tx_sub_q == RT_LAST);
  wire        tx_free   = !tx_busy_q || (tx_left_q == 4'h0);
  wire        take_pre  = tx_on && pre_pend_q;
  wire        take_data = tx_on && !pre_pend_q && !flag_q[F_EMPTY];
  wire        take_brk  = tx_on && !pre_pend_q && flag_q[F_EMPTY] && ctl2_q[C2_BREAK];
  wire        tx_next   = take_pre || take_data || take_brk;
  wire [3:0]  frame_len = nine_bits ? 4'd11 : 4'd10;
  wire [10:0] data_frm  = nine_bits ? {1'b1, ctl1_q[C1_TX_BIT8], tx_data_q, 1'b0}
                                    : {2'b11, tx_data_q, 1'b0};
  wire [10:0] next_frm  = take_pre ? 11'h7ff : (take_data ? data_frm : 11'h000);
  // shifter loads on the bit clock, not on the bus write
  wire        load_tx   = tx_bit && tx_free && take_data;
  // done when nothing is pending, also after a disable
  wire        done_ev   = tx_bit && tx_free && tx_busy_q && !tx_next;
  wire        clk_bit   = (tx_kind_q == TK_DATA) && (tx_pos_q != 4'h0) &&
                          ((tx_pos_q < data_len) ||
                           (tx_pos_q == data_len && ctl1_q[C1_LAST_CLK]));
  wire        clk_half  = ctl1_q[C1_CLK_PHA] ? (tx_sub_q < RT_HALF) : (tx_sub_q >= RT_HALF);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_data_q <= RST_DATA;
    end else if (wr_data) begin
      tx_data_q <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_sub_q     <= 4'h0;
      tx_busy_q    <= 1'b0;
      tx_left_q    <= 4'h0;
      tx_pos_q     <= 4'h0;
      tx_sh_q      <= 11'h7ff;
      tx_kind_q    <= TK_OTHER;
      tx_on_prev_q <= 1'b0;
      pre_pend_q   <= 1'b0;
      tx_out_q     <= 1'b1;
    end else if (ce) begin
      tx_on_prev_q <= tx_on;
      if (tx_rt) begin
        tx_sub_q <= tx_sub_q + 4'h1;
      end
      if (tx_on && !tx_on_prev_q) begin
        pre_pend_q <= 1'b1;
      end else if (tx_bit && tx_free && take_pre) begin
        pre_pend_q <= 1'b0;
      end
      if (tx_bit) begin
        if (tx_free && tx_next) begin
          tx_busy_q <= 1'b1;
          tx_out_q  <= next_frm[0];
          tx_sh_q   <= {1'b1, next_frm[10:1]};
          tx_left_q <= frame_len - 4'h1;
          tx_pos_q  <= 4'h0;
          tx_kind_q <= take_data ? TK_DATA : TK_OTHER;
        end else if (tx_free) begin
          tx_busy_q <= 1'b0;
          tx_out_q  <= 1'b1;
          tx_kind_q <= TK_OTHER;
        end else begin
          // least significant bit leaves first
          tx_out_q  <= tx_sh_q[0];
          tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
          tx_left_q <= tx_left_q - 4'h1;
          tx_pos_q  <= tx_pos_q + 4'h1;
        end
      end
    end
  end

  // pins released only after the frame in flight ends
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_oe_q   <= 1'b0;
      sclk_q    <= 1'b0;
      sclk_oe_q <= 1'b0;
    end else if (ce) begin
      tx_oe_q   <= tx_on || tx_busy_q;
      sclk_oe_q <= tx_on || tx_busy_q;
      // pulses on data bits only, phase and polarity chosen
      sclk_q    <= ctl1_q[C1_CLK_POL] ^ (tx_busy_q && clk_bit && clk_half);
    end
  end

  assign serial_out    = tx_out_q;
  assign serial_out_oe = tx_oe_q;
  assign sync_clk      = sclk_q;
  assign sync_clk_oe   = sclk_oe_q;

  // ---------------- flags and interrupt ----------------
  // hardware set wins over the software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_q <= RST_FLAG;
    end else if (ce) begin
      flag_q[F_EMPTY] <= load_tx || (flag_q[F_EMPTY] && !wr_data);
      flag_q[F_DONE]  <= done_ev || (flag_q[F_DONE] && !wr_data);
      flag_q[F_FULL]  <= load_ev || (flag_q[F_FULL] && !rx_clear);
      flag_q[F_IDLE]  <= idle_ev || (flag_q[F_IDLE] && !rx_clear);
      flag_q[F_OVER]  <= ovr_ev || (flag_q[F_OVER] && !rx_clear);
      // stop bit samples count towards noise as well
      flag_q[F_NOISE] <= (load_ev && (rx_noise_q || vote_bad)) ||
                         (flag_q[F_NOISE] && !rx_clear);
      flag_q[F_FRAME] <= (load_ev && !vote) || (flag_q[F_FRAME] && !rx_clear);
      flag_q[0]       <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= (flag_q[F_EMPTY] && ctl2_q[C2_EMPTY_IE]) ||
             (flag_q[F_DONE] && ctl2_q[C2_DONE_IE]) ||
             ((flag_q[F_FULL] || flag_q[F_OVER]) && ctl2_q[C2_RX_IE]) ||
             (flag_q[F_IDLE] && ctl2_q[C2_IDLE_IE]);
    end
  end

endmodule

// >>> asp_properties.sv
// boundary checks for the serial port
`timescale 1ns/1ps
module asp_props
  import asp_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        serial_out,
  input wire logic        serial_out_oe,
  input wire logic        sync_clk,
  input wire logic        sync_clk_oe,
  input wire logic        irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [7:0] hi_q;
  logic [7:0] hi_d;
  wire        rd_take = ce && hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
  // length of the current high run on the line, saturating
  assign hi_d = !serial_out ? 8'h00 : (&hi_q ? hi_q : hi_q + 8'h01);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hi_q <= 8'h00;
    else
      hi_q <= hi_d;
  end
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or okay");
  chk_rdata_upper: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_rdata_hold: assert property (!rd_take |=> $stable(hrdata))
    else $error("read data moved without a read");
  chk_low_span: assert property ($fell(serial_out) && serial_out_oe |->
    (!serial_out) [*8] ##1 (!serial_out) [*7]) else $error("low bit too short");
  chk_high_span: assert property ($rose(serial_out) && serial_out_oe |->
    serial_out [*8] ##1 serial_out [*7]) else $error("high bit too short");
  chk_clk_half: assert property ($changed(sync_clk) && sync_clk_oe |->
    ##1 $stable(sync_clk) [*7]) else $error("clock pulse shorter than half bit");
  chk_idle_clk: assert property (hi_q > 8'd200 && sync_clk_oe |-> $stable(sync_clk))
    else $error("clock pin moved on idle line");
  chk_release_end: assert property ($fell(serial_out_oe) |-> hi_q >= 8'd8)
    else $error("output released inside a frame");
  chk_pins_pair: assert property (!serial_out_oe |-> !sync_clk_oe)
    else $error("clock pin driven with output released");
  cov_oe_release: cover property ($fell(serial_out_oe));
  cov_clk_pulse: cover property ($changed(sync_clk) && sync_clk_oe);
  cov_irq_rise: cover property ($rose(irq));
endmodule

bind asp_uart asp_props u_props (
  .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
  .sync_clk(sync_clk), .sync_clk_oe(sync_clk_oe), .irq(irq)
);

// >>> asp_peer.sv
// remote serial transceiver model
`timescale 1ns/1ps
module asp_peer (
  input wire logic hclk,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic sync_clk,
  output logic     serial_in_pin
);
  logic [7:0] rx_q[$];
  int         tg_q[$];
  logic [7:0] d;
  logic       p;
  int         t;
  initial serial_in_pin = 1'b1;
  // optional one-cycle glitch in mid first data bit
  task automatic send(input logic [7:0] b, input int bt, input logic stp, input logic gl);
    logic [9:0] f;
    f = {stp, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      for (int k = 0; k < bt; k++) begin
        @(posedge hclk);
        serial_in_pin <= f[i] ^ (gl && i == 1 && k == bt / 2);
      end
    end
    @(posedge hclk);
    serial_in_pin <= 1'b1;
  endtask
  // decode frames and count clock pin edges across each
  initial begin
    forever begin
      @(posedge hclk iff (serial_out_oe && !serial_out));
      t = 0;
      p = sync_clk;
      for (int c = 1; c < 153; c++) begin
        @(posedge hclk);
        t += int'(sync_clk !== p);
        p = sync_clk;
        if (c % 16 == 7 && c > 16 && c < 144)
          d[c / 16 - 1] = serial_out;
      end
      rx_q.push_back(d);
      tg_q.push_back(t);
    end
  end
endmodule

// >>> tb_top.sv
// self-checking bench for the serial port
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    total_checks++; \
    if ((a) !== (b)) begin \
      error_cnt++; \
      $display("Error t=%0t got %h exp %h", $time, (a), (b)); \
    end \
  end
module tb_top;
  import asp_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, serial_in_pin, hreadyout, hresp;
  logic        serial_out, serial_out_oe, sync_clk, sync_clk_oe, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  haddr, b, got, e;
  logic [31:0] hwdata, hrdata, r;
  logic [31:0] seed = 32'h551e560c;
  logic [7:0]  exp_q[$];
  int          error_cnt, total_checks, gt;
  logic [15:0] rst_tab[6] = '{{ADDR_FLAG, RST_FLAG}, {ADDR_CTL1, RST_CTL1},
    {ADDR_CTL2, RST_CTL2}, {ADDR_BAUD, RST_BAUD}, {ADDR_DATA, RST_DATA}, 16'h0000};
  logic [7:0]  bd_tab[3] = '{8'h01, 8'h08, 8'h0a};
  int          bt_tab[3] = '{32, 32, 128};
  asp_uart dut_u (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .serial_in_pin(serial_in_pin),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe), .sync_clk(sync_clk),
    .sync_clk_oe(sync_clk_oe), .irq(irq));
  asp_peer u_peer (.hclk(hclk), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .sync_clk(sync_clk), .serial_in_pin(serial_in_pin));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    #800_000;
    error_cnt++;
    report_and_stop();
  end
  task automatic report_and_stop();
    if (error_cnt == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wait_flag(input int k);
    for (int i = 0; i < 3000; i++) begin
      bus(1'b0, ADDR_FLAG, 8'h00);
      if (r[k] === 1'b1)
        return;
    end
    `CHK(r[k], 1'b1)
  endtask
  task automatic chk_peer(input int tg);
    for (int i = 0; i < 4000 && u_peer.rx_q.size() == 0; i++)
      @(posedge hclk);
    `CHK(u_peer.rx_q.size() > 0, 1'b1)
    if (u_peer.rx_q.size() > 0) begin
      got = u_peer.rx_q.pop_front();
      gt = u_peer.tg_q.pop_front();
      e = exp_q.pop_front();
      `CHK(got, e)
      if (tg >= 0)
        `CHK(gt, tg)
    end
  endtask
  task automatic rx_chk(input logic [7:0] v, input int bt, input logic stp, input logic gl,
                        input int k, input logic cmp);
    u_peer.send(v, bt, stp, gl);
    wait_flag(k);
    `CHK(irq, 1'b1)
    bus(1'b0, ADDR_DATA, 8'h00);
    if (cmp)
      `CHK(r[7:0], v)
  endtask
  task automatic tx_byte();
    b = rnd();
    exp_q.push_back(b);
    bus(1'b1, ADDR_DATA, b);
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    hwrite = 1'b0;
    htrans = 2'b00;
    hsize = 3'b010;
    haddr = 8'h00;
    hwdata = 32'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rst_tab[i]) begin
      bus(1'b0, rst_tab[i][15:8], 8'h00);
      `CHK(r, {24'h0, rst_tab[i][7:0]})
    end
    bus(1'b1, ADDR_CTL1, 8'hff);
    bus(1'b0, ADDR_CTL1, 8'h00);
    `CHK(r[7:0], C1_WR_MASK)
    bus(1'b1, ADDR_CTL1, 8'h07);
    bus(1'b1, ADDR_CTL2, 8'h3c);
    bus(1'b0, ADDR_CTL2, 8'h00);
    `CHK(r[7:0], 8'h3c)
    for (int i = 0; i < 3; i++) begin
      wait_flag(F_EMPTY);
      tx_byte();
    end
    repeat (3) chk_peer(16);
    wait_flag(F_DONE);
    `CHK(r[7:6], 2'b11)
    tx_byte();
    wait_flag(F_EMPTY);
    bus(1'b1, ADDR_CTL2, 8'h34);
    wait_flag(F_DONE);
    chk_peer(-1);
    `CHK(serial_out_oe, 1'b0)
    `CHK(sync_clk_oe, 1'b0)
    bus(1'b1, ADDR_CTL1, 8'h06);
    bus(1'b1, ADDR_CTL2, 8'h3c);
    tx_byte();
    chk_peer(14);
    bus(1'b1, ADDR_CTL1, 8'h56);
    tx_byte();
    chk_peer(16);
    bus(1'b1, ADDR_CTL2, 8'h3d);
    exp_q.push_back(8'h00);
    chk_peer(0);
    bus(1'b1, ADDR_CTL2, 8'h3c);
    bus(1'b1, ADDR_CTL1, 8'h06);
    rx_chk(rnd(), 16, 1'b1, 1'b0, F_FULL, 1'b1);
    repeat (2) @(posedge hclk);
    `CHK(irq, 1'b0)
    wait_flag(F_IDLE);
    `CHK(irq, 1'b1)
    bus(1'b0, ADDR_DATA, 8'h00);
    rx_chk(rnd(), 16, 1'b1, 1'b1, F_NOISE, 1'b1);
    rx_chk(rnd(), 16, 1'b0, 1'b0, F_FRAME, 1'b0);
    u_peer.send(rnd(), 16, 1'b1, 1'b0);
    rx_chk(rnd(), 16, 1'b1, 1'b0, F_OVER, 1'b0);
    bus(1'b1, ADDR_CTL1, 8'h0e);
    bus(1'b1, ADDR_CTL2, 8'h3e);
    u_peer.send(8'h12, 16, 1'b1, 1'b0);
    bus(1'b0, ADDR_FLAG, 8'h00);
    `CHK({r[5], r[3:1]}, 4'h0)
    u_peer.send(8'h92, 16, 1'b1, 1'b0);
    bus(1'b0, ADDR_CTL2, 8'h00);
    `CHK(r[C2_SLEEP], 1'b0)
    rx_chk(rnd(), 16, 1'b1, 1'b0, F_FULL, 1'b1);
    foreach (bd_tab[i]) begin
      bus(1'b1, ADDR_CTL2, 8'h00);
      bus(1'b1, ADDR_BAUD, bd_tab[i]);
      bus(1'b1, ADDR_CTL2, 8'h24);
      rx_chk(rnd(), bt_tab[i], 1'b1, 1'b0, F_FULL, 1'b1);
    end
    report_and_stop();
  end
endmodule
